// File: rtl/fwa_pkg.sv
// package: constants and carrier types for the flash wait and abort control block
package fwa_pkg;
  // ****************************************************************
  // command codes and geometry
  // ****************************************************************
  localparam logic [1:0]  CMD_PROGRAM   = 2'h1;
  localparam logic [1:0]  CMD_ERASE     = 2'h2;
  localparam int          NUM_BLOCKS    = 8;
  localparam int          BLK_W         = 3;
  localparam logic [2:0]  BLK_A         = 3'h0;
  localparam logic [2:0]  BLK_B         = 3'h1;
  localparam int          CNT_W         = 16;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  // ****************************************************************
  // timing counts: base duration plus growth with wear
  // ****************************************************************
  localparam int          PROG_BASE_NS  = 80;
  localparam int          ERASE_BASE_NS = 400;
  localparam int          CLK_NS        = 4;
  localparam logic [19:0] PROG_BASE_CYC  = 20'(PROG_BASE_NS / CLK_NS);
  localparam logic [19:0] ERASE_BASE_CYC = 20'(ERASE_BASE_NS / CLK_NS);
  localparam int          WEAR_SHIFT    = 2;
  localparam logic [1:0]  WAIT_ONE      = 2'h1;
  localparam logic        AB_WAIT_RESET = 1'b0;

  typedef struct packed {
    logic             valid;
    logic [1:0]       cmd;
    logic [BLK_W-1:0] blk;
  } fwa_cmd_t;

  typedef struct packed {
    logic             valid;
    logic             is_ram;
    logic [BLK_W-1:0] blk;
  } fwa_acc_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b100
  } fwa_state_t;
endpackage : fwa_pkg

// File: rtl/fwa_ctrl.sv
// module: flash command sequencing, abort, wear counting, wait-state and boot pull-up
`timescale 1ns/1ps
module fwa_ctrl
  import fwa_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            hw_reset2_n,
  input  wire logic            nmi,
  input  wire logic            wdt_irq,
  input  wire fwa_pkg::fwa_cmd_t cmd_in,
  input  wire fwa_pkg::fwa_acc_t acc_in,
  input  wire logic            ab_sel_wr,
  input  wire logic            ab_sel_wdata,
  input  wire logic            global_wait_select,
  input  wire logic            boot_mode_pin,
  input  wire logic            reset_pin_n,
  output logic                 busy,
  output logic                 done,
  output logic                 aborted,
  output logic [1:0]           wait_states,
  output logic                 block_ab_wait_select,
  output logic                 boot_pullup_port_pin,
  output logic [15:0]          wear_count_a
);
  import fwa_pkg::*;

  fwa_state_t       state_r;
  logic [19:0]      timer_r;
  logic [BLK_W-1:0] blk_r;
  logic [15:0]      wear_r [NUM_BLOCKS];
  logic             abort_req;

  // duration of a command: base plus a wear term, so worn blocks run longer
  function automatic logic [19:0] cmd_cycles(input logic [19:0] base, input logic [15:0] wear);
    cmd_cycles = base + 20'(wear >> WEAR_SHIFT);
  endfunction : cmd_cycles

  assign abort_req = !hw_reset2_n || nmi || wdt_irq;

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    done    <= 1'b0;
    aborted <= 1'b0;
    if (!reset_n) begin
      state_r <= ST_IDLE;
      timer_r <= 20'h00000;
      blk_r   <= '0;
      busy    <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_in.valid && !abort_req && cmd_in.cmd == CMD_PROGRAM) begin
            state_r <= ST_PROG;
            blk_r   <= cmd_in.blk;
            timer_r <= cmd_cycles(PROG_BASE_CYC, wear_r[cmd_in.blk]);
            busy    <= 1'b1;
          end else if (cmd_in.valid && !abort_req && cmd_in.cmd == CMD_ERASE) begin
            state_r <= ST_ERASE;
            blk_r   <= cmd_in.blk;
            timer_r <= cmd_cycles(ERASE_BASE_CYC, wear_r[cmd_in.blk]);
            busy    <= 1'b1;
          end
        end
        ST_PROG, ST_ERASE: begin
          // abandon running command
          // abort is tested first: a source in the final cycle still cuts the command
          if (abort_req) begin
            state_r <= ST_IDLE;
            busy    <= 1'b0;
            aborted <= 1'b1;
          end else if (timer_r <= 20'h00001) begin
            state_r <= ST_IDLE;
            busy    <= 1'b0;
            done    <= 1'b1;
          end else begin
            timer_r <= timer_r - 20'h00001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // wear counters, one per block
  // ****************************************************************
  // advance only on completed erase
  // a cut erase leaves the count alone, since the block is not known to be erased
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_BLOCKS; i++) wear_r[i] <= CNT_RESET;
    end else if (state_r == ST_ERASE && !abort_req && timer_r <= 20'h00001
                 && wear_r[blk_r] != CNT_MAX) begin
      wear_r[blk_r] <= wear_r[blk_r] + 16'h0001; // saturates, never wraps
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) wear_count_a <= CNT_RESET;
    else          wear_count_a <= wear_r[BLK_A];
  end

  // ****************************************************************
  // wait-state selection
  // ****************************************************************
  // ab select defaults low
  always_ff @(posedge clk) begin
    if (!reset_n)       block_ab_wait_select <= AB_WAIT_RESET;
    else if (ab_sel_wr) block_ab_wait_select <= ab_sel_wdata;
  end

  // registered wait count, valid the cycle after the access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wait_states <= 2'h0;
    end else if (!acc_in.valid) begin
      wait_states <= 2'h0;
    end else if (!acc_in.is_ram && (acc_in.blk == BLK_A || acc_in.blk == BLK_B)
                 && block_ab_wait_select) begin
      wait_states <= WAIT_ONE;
    end else begin
      wait_states <= global_wait_select ? WAIT_ONE : 2'h0;
    end
  end

  // ****************************************************************
  // boot pull-up
  // ****************************************************************
  // pull-up while boot high, reset low
  always_ff @(posedge clk) begin
    if (!reset_n) boot_pullup_port_pin <= 1'b0;
    else          boot_pullup_port_pin <= boot_mode_pin && !reset_pin_n;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_abort_stops_cmd: assert property (busy && abort_req |=> !busy && aborted)
    else $error("command not abandoned on abort");
  chk_no_start_abort: assert property (!busy && abort_req |=> !busy)
    else $error("command started during abort");
  // unworn program length, unless cut short
  chk_prog_len: assert property (
    !busy && cmd_in.valid && cmd_in.cmd == CMD_PROGRAM && !abort_req
      && wear_r[cmd_in.blk] == 16'h0000
      |-> (##1 busy [*8] ##12 busy ##1 done) or (##[2:21] aborted))
    else $error("program length wrong");
  chk_wear_hold: assert property (state_r != ST_ERASE |=> $stable(wear_r[BLK_A]))
    else $error("wear moved without erase");
  chk_wear_step: assert property (
    done && $past(state_r) == ST_ERASE && $past(blk_r) == BLK_A && wear_count_a != CNT_MAX
      |=> wear_count_a == $past(wear_count_a) + 16'h0001)
    else $error("erase did not advance wear");
  // one wait on A and B
  chk_ab_wait: assert property (
    acc_in.valid && !acc_in.is_ram && (acc_in.blk == BLK_A || acc_in.blk == BLK_B)
      && block_ab_wait_select |=> wait_states == 2'h1)
    else $error("A/B wait missing");
  chk_other_wait: assert property (
    acc_in.valid && acc_in.is_ram |=> wait_states == {1'b0, $past(global_wait_select)})
    else $error("RAM wait not from global select");
  chk_block_wait: assert property (
    acc_in.valid && !acc_in.is_ram && acc_in.blk != BLK_A && acc_in.blk != BLK_B
      |=> wait_states == {1'b0, $past(global_wait_select)})
    else $error("block wait not from global select");
  chk_wait_idle: assert property (!acc_in.valid |=> wait_states == 2'h0)
    else $error("wait without access");
  chk_pullup: assert property (
    boot_mode_pin && !reset_pin_n |=> boot_pullup_port_pin)
    else $error("boot pull-up missing");
  chk_pullup_off: assert property (
    !boot_mode_pin || reset_pin_n |=> !boot_pullup_port_pin)
    else $error("boot pull-up left on");
  chk_ab_reset: assert property ($rose(reset_n) |-> !block_ab_wait_select)
    else $error("ab select not cleared");
  chk_ab_write: assert property (
    ab_sel_wr |=> block_ab_wait_select == $past(ab_sel_wdata))
    else $error("ab select write lost");

  // main scenarios: completion, abort by interrupt and by reset, forced wait
  cov_prog_done: cover property (state_r == ST_PROG ##1 done);
  cov_reset2_abort: cover property (busy && !hw_reset2_n ##1 aborted);
  cov_erase_abort: cover property (state_r == ST_ERASE && nmi ##1 aborted);
  cov_ab_wait: cover property (block_ab_wait_select && acc_in.valid ##1 wait_states == 2'h1);
endmodule : fwa_ctrl

// File: test/fwa_cpu_model.sv
// partner model: cpu side that issues flash commands
`timescale 1ns/1ps
module fwa_cpu_model
  import fwa_pkg::*;
(
  input  wire logic              busy,
  input  wire fwa_pkg::fwa_cmd_t req,
  output fwa_pkg::fwa_cmd_t      cmd_out
);
  // retry, single-program and wear policy sit in the caller
  // requests are held off while busy, so none overlaps a running command
  assign cmd_out = busy ? '0 : req;
endmodule : fwa_cpu_model

// File: test/tb.sv
// testbench: wait-state table, command timing, wear, abort and boot pull-up
`timescale 1ns/1ps
module tb;
  import fwa_pkg::*;
  logic        clk, reset_n, hw_reset2_n, nmi, wdt_irq, ab_sel_wr, ab_sel_wdata;
  logic        global_wait_select, boot_mode_pin, reset_pin_n, busy, done, aborted;
  logic        block_ab_wait_select, boot_pullup_port_pin;
  logic [1:0]  wait_states;
  logic [15:0] wear_count_a;
  fwa_cmd_t    req, cmd_in;
  fwa_acc_t    acc_in;
  int          n_fail, tests_run, n, i;
  // {hw_reset2_n, nmi, wdt_irq} with no abort source active
  localparam logic [2:0] IDLE_SRC = 3'b100;
  // rows: {ab select, global select, is ram, blk[2:0], expected wait}
  logic [6:0]  rows [8] = '{7'h41, 7'h43, 7'h00, 7'h23, 7'h44, 7'h2b, 7'h50, 7'h71};

  fwa_ctrl fwa_ctrl_i (.clk(clk), .reset_n(reset_n), .hw_reset2_n(hw_reset2_n), .nmi(nmi),
    .wdt_irq(wdt_irq), .cmd_in(cmd_in), .acc_in(acc_in), .ab_sel_wr(ab_sel_wr),
    .ab_sel_wdata(ab_sel_wdata), .global_wait_select(global_wait_select),
    .boot_mode_pin(boot_mode_pin), .reset_pin_n(reset_pin_n), .busy(busy), .done(done),
    .aborted(aborted), .wait_states(wait_states), .block_ab_wait_select(block_ab_wait_select),
    .boot_pullup_port_pin(boot_pullup_port_pin), .wear_count_a(wear_count_a));
  fwa_cpu_model fwa_cpu_model_i (.busy(busy), .req(req), .cmd_out(cmd_in));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // one command; counts busy cycles until done or abort; after 8 busy cycles
  // src goes onto the abort inputs and stays there for the caller to clear
  task automatic cmd(input logic [1:0] c, input logic [2:0] b, input logic [2:0] src,
                     output int cnt);
    int k;
    cnt = 0;
    req = '{1'b1, c, b};
    @(negedge clk);
    req = '0;
    for (k = 0; k < 400 && done !== 1'b1 && aborted !== 1'b1; k++) begin
      if (busy === 1'b1) cnt++;
      if (cnt == 8) {hw_reset2_n, nmi, wdt_irq} = src;
      @(negedge clk);
    end
  endtask : cmd

  // watchdog: the full run needs about 1100 cycles
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end

  // main sequence, inputs change at falling edges
  initial begin
    {reset_n, hw_reset2_n, nmi, wdt_irq, ab_sel_wr, ab_sel_wdata} = 6'h10;
    {global_wait_select, boot_mode_pin, reset_pin_n} = 3'h1;
    req = '0;
    acc_in = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk("ab_select", 20'(AB_WAIT_RESET), 20'(block_ab_wait_select));
    chk("busy", 20'h0, 20'(busy));
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      ab_sel_wr = 1'b1;
      ab_sel_wdata = rows[i][6];
      global_wait_select = rows[i][5];
      @(negedge clk);
      ab_sel_wr = 1'b0;
      acc_in = '{1'b1, rows[i][4], rows[i][3:1]};
      @(negedge clk);
      acc_in = '0;
      chk("wait_states", 20'(rows[i][0]), 20'(wait_states));
    end
    $display("test wait table done");
    // hardware reset 1 in mid-erase: command dropped, ab select cleared
    req = '{1'b1, CMD_ERASE, 3'h3};
    @(negedge clk);
    req = '0;
    repeat (4) @(negedge clk);
    chk("busy_erase", 20'h1, 20'(busy));
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk("busy_reset", 20'h0, 20'(busy));
    chk("ab_select_reset", 20'(AB_WAIT_RESET), 20'(block_ab_wait_select));
    $display("test mid reset done");
    cmd(CMD_PROGRAM, BLK_A, IDLE_SRC, n);
    chk("prog_len", PROG_BASE_CYC, 20'(n));
    chk("done", 20'h1, 20'(done));
    for (i = 0; i < 4; i++) begin
      cmd(CMD_ERASE, BLK_A, IDLE_SRC, n);
      chk("erase_len", ERASE_BASE_CYC + 20'(i >> WEAR_SHIFT), 20'(n));
    end
    cmd(CMD_ERASE, BLK_B, IDLE_SRC, n);
    // block A was erased since its first program
    cmd(CMD_PROGRAM, BLK_A, IDLE_SRC, n);
    chk("prog_worn", PROG_BASE_CYC + 20'(4 >> WEAR_SHIFT), 20'(n));
    @(negedge clk);
    chk("wear_a", 20'h4, 20'(wear_count_a));
    $display("test wear done");
    for (i = 0; i < 3; i++) begin
      cmd(CMD_ERASE, BLK_A, IDLE_SRC ^ (IDLE_SRC >> i), n);
      chk("aborted", 20'h1, 20'(aborted));
      chk("abort_len", 20'h8, 20'(n));
      chk("wear_kept", 20'(4 + i), 20'(wear_count_a));
      req = '{1'b1, CMD_ERASE, BLK_A};
      @(negedge clk);
      req = '0;
      {hw_reset2_n, nmi, wdt_irq} = IDLE_SRC;
      chk("refused", 20'h0, 20'(busy));
      // the cut block is erased before it is used again
      cmd(CMD_ERASE, BLK_A, IDLE_SRC, n);
      chk("erase_worn", ERASE_BASE_CYC + 20'((4 + i) >> WEAR_SHIFT), 20'(n));
    end
    cmd(CMD_PROGRAM, 3'h2, 3'b110, n);
    chk("prog_abort", 20'h8, 20'(n));
    {hw_reset2_n, nmi, wdt_irq} = IDLE_SRC;
    // erase the cut block before the program is issued again
    cmd(CMD_ERASE, 3'h2, IDLE_SRC, n);
    cmd(CMD_PROGRAM, 3'h2, IDLE_SRC, n);
    chk("prog_retry", PROG_BASE_CYC, 20'(n));
    $display("test abort done");
    for (i = 0; i < 4; i++) begin
      // both low, boot pin raised, then reset released
      {boot_mode_pin, reset_pin_n} = 2'(8'h78 >> (2 * i));
      @(negedge clk);
      chk("pullup", 20'(i == 1), 20'(boot_pullup_port_pin));
    end
    $display("test pullup done");
    end_sim;
  end
endmodule : tb
